// file: pkg/gdma_defines.vh
/*
 * constants for the general dma channel: register offsets, field
 * positions, reset values, mode codes and rate-window figures.
 * assumes inclusion by bare name from the channel design file.
 */
`ifndef GDMA_DEFINES_VH
`define GDMA_DEFINES_VH

// ************************************************************
// register byte offsets on the apb slave
// ************************************************************
`define GDMA_OFF_MODE     8'h00
`define GDMA_OFF_SRC      8'h04
`define GDMA_OFF_DST      8'h08
`define GDMA_OFF_FC       8'h0c
`define GDMA_OFF_COUNT    8'h10
`define GDMA_OFF_STATUS   8'h14
`define GDMA_OFF_BUSCFG   8'h18

// ************************************************************
// reset values
// ************************************************************
`define GDMA_MODE_RST     16'h0000
`define GDMA_PTR_RST      24'h00_0000
`define GDMA_COUNT_RST    16'h0000
`define GDMA_FC_RST       6'h00
`define GDMA_STATUS_RST   4'h0

// ************************************************************
// mode register fields
// ************************************************************
`define GDMA_M_ECO        14
`define GDMA_M_NORMAL_COMPLETION_IRQ_ENABLE       13
`define GDMA_M_ERROR_IRQ_ENABLE       12
`define GDMA_M_REQ_HI     11
`define GDMA_M_REQ_LO     10
`define GDMA_M_SOURCE_INCREMENT       9
`define GDMA_M_DESTINATION_INCREMENT       8
`define GDMA_M_SS_HI      7
`define GDMA_M_SS_LO      6
`define GDMA_M_DS_HI      5
`define GDMA_M_DS_LO      4
`define GDMA_M_BT_HI      3
`define GDMA_M_BT_LO      2
`define GDMA_M_RST        1
`define GDMA_M_STR        0

// ************************************************************
// status register fields
// ************************************************************
`define GDMA_S_DNS        3
`define GDMA_S_BES        2
`define GDMA_S_BED        1
`define GDMA_S_DONE       0

// ************************************************************
// codes and rate window
// ************************************************************
`define GDMA_REQ_LIMIT    2'h0
`define GDMA_REQ_MAX      2'h1
`define GDMA_REQ_LEVEL    2'h2
`define GDMA_REQ_EDGE     2'h3
`define GDMA_SZ_WORD      2'h2
`define GDMA_SHARE_75     10'h300
`define GDMA_SHARE_50     10'h200
`define GDMA_SHARE_25     10'h100
`define GDMA_SHARE_12     10'h080
`define GDMA_WIN_LAST     10'h3ff

`endif

// file: hdl/gdma_channel.v
/*
 * general dma channel: apb register slave plus an asynchronous
 * 24-bit bus master moving byte/word operands with packing.
 * assumes an external bus arbiter has granted the bus, and that
 * bus handshake pins are asynchronous to pclk.
 */
// Chosen here: the register addresses and register access over APB.
// Overview of operation
// - both even: word read then word write
// - odd source: two byte reads, word write
// - odd destination: word read, two byte writes
// - both odd: two byte reads, two writes
// - two to four plain bus cycles each
// - 24-bit address, 8- or 16-bit data
// - honour halt, bus error, reset, retry
// - hidden 16-bit holding register packs operands
// - side select picks handshake read or write
// - normal done flag; irq if enabled
// - bus error flags; irq if enabled
// - irq gated by controller mask bit
// - request field selects four request modes
// - source pointer steps one/two or holds
// - destination pointer steps one/two or holds
// - size codes: 01 byte, 10 word
// - burst share caps use per window
// - share caps only in limited mode
// - limited mode runs while clear negated
// - soft reset aborts, clears, self-clears
// - start bit begins or arms requests
// - start bit self-clears on completion
// - clearing start pauses after current operand
// - byte count steps; zero means 64K
// - done driven during final bus cycle
`timescale 1ns/100ps
`include "gdma_defines.vh"
`default_nettype none

module gdma_channel (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg  [23:0] bus_addr,
  output reg  [2:0]  bus_fc,
  output reg         bus_rw,
  output reg         bus_as_n,
  output reg         bus_uds_n,
  output reg         bus_lds_n,
  output reg  [15:0] bus_data_out,
  output reg         bus_data_oe,
  input  wire [15:0] bus_data_in,
  input  wire        bus_dtack_n,
  input  wire        bus_berr_n,
  input  wire        bus_halt_n,
  input  wire        bus_reset_n,
  input  wire        bus_clear_input_n,
  input  wire        peripheral_request_n,
  output reg         peripheral_acknowledge_n,
  input  wire        done_in_n,
  output reg         done_out_n,
  output reg         done_oe,
  input  wire        interrupt_mask_bit,
  output reg         irq_request
);

  // ************************************************************
  // state codes
  // ************************************************************
  localparam ST_IDLE  = 4'b0001;
  localparam ST_ADDR  = 4'b0010;
  localparam ST_WAIT  = 4'b0100;
  localparam ST_RETRY = 4'b1000;

  // ************************************************************
  // helper functions
  // ************************************************************
  // bytes in one operand, cut to one by a final odd count
  function [1:0] op_bytes;
    input [1:0]  ss;
    input [1:0]  ds;
    input [15:0] cnt;
    begin
      op_bytes = (((ss == `GDMA_SZ_WORD) | (ds == `GDMA_SZ_WORD)) &
                  (cnt != 16'h0001)) ? 2'h2 : 2'h1;
    end
  endfunction

  // bus accesses needed on one side of an operand
  function [1:0] acc_count;
    input       word_sz;
    input       a0;
    input       p16;
    input [1:0] nb;
    begin
      acc_count = ((nb == 2'h2) & ~(word_sz & ~a0 & p16)) ? 2'h2 : 2'h1;
    end
  endfunction

  // bus clocks allowed per window
  function [9:0] share_limit;
    input [1:0] bt;
    begin
      case (bt)
        2'h0:    share_limit = `GDMA_SHARE_75;
        2'h1:    share_limit = `GDMA_SHARE_50;
        2'h2:    share_limit = `GDMA_SHARE_25;
        default: share_limit = `GDMA_SHARE_12;
      endcase
    end
  endfunction

  // pointer after one access, wrapping at 24 bits
  function [23:0] ptr_step;
    input [23:0] p;
    input        inc;
    input        word;
    begin
      ptr_step = inc ? p + {22'h00_0000, word, ~word} : p;
    end
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  reg [15:0] mode_q;
  reg        soft_rst_q;
  reg [23:0] src_q;
  reg [23:0] dst_q;
  reg [5:0]  fc_q;
  reg [15:0] count_q;
  reg [3:0]  status_q;
  reg        port16_q;
  reg [3:0]  st_q;
  reg        phase_q;
  reg        acc_q;
  reg [1:0]  nbytes_q;
  reg [15:0] hold_q;
  reg        term_pend_q;
  reg        edge_pend_q;
  reg        req_prev_q;
  reg [9:0]  win_q;
  reg [9:0]  used_q;
  reg [6:0]  meta_q;
  reg [6:0]  sync_q;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  wire [6:0] async_in = {~bus_dtack_n, ~bus_berr_n, ~bus_halt_n,
                         ~bus_reset_n, ~done_in_n,
                         ~peripheral_request_n, ~bus_clear_input_n};

  // two flops on every bus control and handshake pin; bus_data_in is sampled unsynchronised
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 7'h00;
      sync_q <= 7'h00;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  wire dtack_s = sync_q[6];
  wire berr_s  = sync_q[5];
  wire halt_s  = sync_q[4];
  wire brst_s  = sync_q[3];
  wire done_s  = sync_q[2];
  wire peripheral_request_s  = sync_q[1];
  wire bus_clear_input_s  = sync_q[0];

  // ************************************************************
  // decode
  // ************************************************************
  wire       apb_acc = psel & penable & pready;
  wire       apb_wr  = apb_acc & pwrite;
  wire       wr_mode = apb_wr & (paddr == `GDMA_OFF_MODE);
  wire       wr_stat = apb_wr & (paddr == `GDMA_OFF_STATUS);
  wire [1:0] request_source_field    = mode_q[`GDMA_M_REQ_HI:`GDMA_M_REQ_LO];
  wire [1:0] source_operand_size   = mode_q[`GDMA_M_SS_HI:`GDMA_M_SS_LO];
  wire [1:0] destination_operand_size   = mode_q[`GDMA_M_DS_HI:`GDMA_M_DS_LO];
  wire [1:0] bt      = mode_q[`GDMA_M_BT_HI:`GDMA_M_BT_LO];
  wire       ext     = request_source_field[1];
  wire       start   = mode_q[`GDMA_M_STR];
  wire       kill    = soft_rst_q | brst_s;

  // current side of the operand
  wire [23:0] cur_addr = phase_q ? dst_q : src_q;
  wire        cur_word = phase_q ? (destination_operand_size == `GDMA_SZ_WORD)
                                 : (source_operand_size == `GDMA_SZ_WORD);
  wire [1:0]  n_acc    = acc_count(cur_word, cur_addr[0], port16_q,
                                   nbytes_q);
  wire        acc_word = (n_acc == 2'h1) & (nbytes_q == 2'h2) & ~acc_q;
  wire        last_acc = acc_q | (n_acc == 2'h1);
  wire [1:0]  acc_bytes = acc_word ? 2'h2 : 2'h1;
  wire [15:0] count_next = count_q - {14'h0000, acc_bytes};
  wire        periph_side = ext & (phase_q == mode_q[`GDMA_M_ECO]);

  // bus termination decode, only while strobes are out
  wire in_wait   = (st_q == ST_WAIT) & ~bus_as_n;
  wire cyc_err   = in_wait & berr_s & ~halt_s;
  wire cyc_retry = in_wait & berr_s & halt_s;
  wire cyc_ok    = in_wait & dtack_s & ~berr_s;
  wire done_ext  = done_s & ~done_oe & (st_q != ST_IDLE);
  wire op_end    = cyc_ok & phase_q & last_acc;
  wire finish    = op_end & ((count_next == 16'h0000) | term_pend_q |
                             done_ext);
  wire set_dns   = done_ext & periph_side & (n_acc == 2'h2) & ~acc_q;

  // request qualification
  reg req_ok;
  always @* begin
    case (request_source_field)
      `GDMA_REQ_LIMIT: req_ok = (used_q < share_limit(bt)) & ~bus_clear_input_s;
      `GDMA_REQ_MAX:   req_ok = 1'b1;
      `GDMA_REQ_LEVEL: req_ok = peripheral_request_s;
      default:         req_ok = edge_pend_q;
    endcase
  end

  wire go = start & ~halt_s & req_ok;

  // read byte lane: odd bytes on the low lane of a 16-bit port
  wire [7:0] rd_byte = (~port16_q | cur_addr[0]) ? bus_data_in[7:0]
                                                 : bus_data_in[15:8];
  wire [7:0] wr_byte = acc_q ? hold_q[7:0] : hold_q[15:8];

  // ************************************************************
  // register read mux
  // ************************************************************
  reg [31:0] rd_mux;
  reg        rd_bad;
  always @* begin
    rd_bad = 1'b0;
    case (paddr)
      `GDMA_OFF_MODE:   rd_mux = {16'h0000, 1'b0, mode_q[14:2],
                                  soft_rst_q, mode_q[0]};
      `GDMA_OFF_SRC:    rd_mux = {8'h00, src_q};
      `GDMA_OFF_DST:    rd_mux = {8'h00, dst_q};
      `GDMA_OFF_FC:     rd_mux = {25'h000_0000, fc_q[5:3], 1'b0,
                                  fc_q[2:0]};
      `GDMA_OFF_COUNT:  rd_mux = {16'h0000, count_q};
      `GDMA_OFF_STATUS: rd_mux = {28'h000_0000, status_q};
      `GDMA_OFF_BUSCFG: rd_mux = {31'h0000_0000, port16_q};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_bad = 1'b1;
      end
    endcase
  end

  // ************************************************************
  // apb answer: one wait state, registered data and error
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= rd_mux;
      pslverr <= psel & penable & ~pready & rd_bad;
    end
  end

  // ************************************************************
  // status flags and interrupt request
  // ************************************************************
  // set wins over a write-one clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q    <= `GDMA_STATUS_RST;
      irq_request <= 1'b0;
    end else if (kill) begin
      status_q    <= `GDMA_STATUS_RST;
      irq_request <= 1'b0;
    end else begin
      status_q <= (status_q & ~(wr_stat ? pwdata[3:0] : 4'h0)) |
                  {set_dns, cyc_err & ~phase_q, cyc_err & phase_q,
                   finish};
      irq_request <= ((status_q[`GDMA_S_DONE] & mode_q[`GDMA_M_NORMAL_COMPLETION_IRQ_ENABLE]) |
                      ((status_q[`GDMA_S_BES] | status_q[`GDMA_S_BED]) &
                       mode_q[`GDMA_M_ERROR_IRQ_ENABLE])) & interrupt_mask_bit;
    end
  end

  // ************************************************************
  // rate window and cycle-steal edge
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_q       <= 10'h000;
      used_q      <= 10'h000;
      edge_pend_q <= 1'b0;
      req_prev_q  <= 1'b0;
    end else begin
      req_prev_q <= peripheral_request_s;
      if (!start || kill) begin
        win_q  <= 10'h000;
        used_q <= 10'h000;
      end else begin
        win_q <= win_q + 10'h001;
        if (win_q == `GDMA_WIN_LAST)
          used_q <= 10'h000;
        else if (st_q != ST_IDLE)
          used_q <= used_q + 10'h001;
      end
      // new edge wins over the take at operand start
      if (kill)
        edge_pend_q <= 1'b0;
      else if (peripheral_request_s & ~req_prev_q)
        edge_pend_q <= 1'b1;
      else if ((st_q == ST_IDLE) & go)
        edge_pend_q <= 1'b0;
    end
  end

  // ************************************************************
  // registers, operand sequencer and bus master
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q      <= `GDMA_MODE_RST;
      soft_rst_q  <= 1'b0;
      src_q       <= `GDMA_PTR_RST;
      dst_q       <= `GDMA_PTR_RST;
      fc_q        <= `GDMA_FC_RST;
      count_q     <= `GDMA_COUNT_RST;
      port16_q    <= 1'b1;
      st_q        <= ST_IDLE;
      phase_q     <= 1'b0;
      acc_q       <= 1'b0;
      nbytes_q    <= 2'h1;
      hold_q      <= 16'h0000;
      term_pend_q <= 1'b0;
      bus_addr    <= `GDMA_PTR_RST;
      bus_fc      <= 3'h0;
      bus_rw      <= 1'b1;
      bus_as_n    <= 1'b1;
      bus_uds_n   <= 1'b1;
      bus_lds_n   <= 1'b1;
      bus_data_out <= 16'h0000;
      bus_data_oe <= 1'b0;
      peripheral_acknowledge_n <= 1'b1;
      done_out_n  <= 1'b1;
      done_oe     <= 1'b0;
    end else if (kill) begin
      // abort any cycle, clear mode, state and strobes; pointers, count and fc keep their values
      mode_q      <= `GDMA_MODE_RST;
      soft_rst_q  <= 1'b0;
      st_q        <= ST_IDLE;
      term_pend_q <= 1'b0;
      bus_as_n    <= 1'b1;
      bus_uds_n   <= 1'b1;
      bus_lds_n   <= 1'b1;
      bus_data_oe <= 1'b0;
      peripheral_acknowledge_n <= 1'b1;
      done_out_n  <= 1'b1;
      done_oe     <= 1'b0;
    end else begin
      // software writes; they win over the sequencer's updates
      if (wr_mode) begin
        mode_q     <= {1'b0, pwdata[14:2], 1'b0, pwdata[0]};
        soft_rst_q <= pwdata[`GDMA_M_RST];
      end else if (finish | cyc_err)
        mode_q[`GDMA_M_STR] <= 1'b0;
      if (apb_wr & (paddr == `GDMA_OFF_FC))
        fc_q <= {pwdata[6:4], pwdata[2:0]};
      if (apb_wr & (paddr == `GDMA_OFF_BUSCFG))
        port16_q <= pwdata[0];
      if (apb_wr & (paddr == `GDMA_OFF_SRC))
        src_q <= pwdata[23:0];
      else if (cyc_ok & ~phase_q)
        src_q <= ptr_step(src_q, mode_q[`GDMA_M_SOURCE_INCREMENT], acc_word);
      if (apb_wr & (paddr == `GDMA_OFF_DST))
        dst_q <= pwdata[23:0];
      else if (cyc_ok & phase_q)
        dst_q <= ptr_step(dst_q, mode_q[`GDMA_M_DESTINATION_INCREMENT], acc_word);
      if (apb_wr & (paddr == `GDMA_OFF_COUNT))
        count_q <= pwdata[15:0];
      else if (cyc_ok & phase_q)
        count_q <= count_next;
      if (done_ext)
        term_pend_q <= 1'b1;

      case (st_q)
        ST_IDLE: begin
          term_pend_q <= 1'b0;
          if (go) begin
            nbytes_q <= op_bytes(source_operand_size, destination_operand_size, count_q);
            phase_q  <= 1'b0;
            acc_q    <= 1'b0;
            st_q     <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          // address phase; halt or a stale synced answer holds it off
          if (!halt_s & ~dtack_s & ~berr_s) begin
            bus_addr    <= cur_addr;
            bus_fc      <= phase_q ? fc_q[5:3] : fc_q[2:0];
            bus_rw      <= ~phase_q;
            bus_data_out <= acc_word ? hold_q : {wr_byte, wr_byte};
            bus_data_oe <= phase_q;
            peripheral_acknowledge_n <= ~periph_side;
            done_oe     <= phase_q & last_acc &
                           (count_next == 16'h0000);
            done_out_n  <= ~(phase_q & last_acc &
                             (count_next == 16'h0000));
            st_q        <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (bus_as_n) begin
            // strobes one clock after the address
            bus_as_n  <= 1'b0;
            bus_uds_n <= ~(acc_word | (port16_q & ~cur_addr[0]));
            bus_lds_n <= ~(acc_word | ~port16_q | cur_addr[0]);
          end else if (cyc_err | cyc_retry | cyc_ok) begin
            bus_as_n    <= 1'b1;
            bus_uds_n   <= 1'b1;
            bus_lds_n   <= 1'b1;
            bus_data_oe <= 1'b0;
            peripheral_acknowledge_n <= 1'b1;
            done_oe     <= 1'b0;
            done_out_n  <= 1'b1;
            if (cyc_retry)
              st_q <= ST_RETRY;
            else if (cyc_err)
              st_q <= ST_IDLE;
            else begin
              if (!phase_q) begin
                // pack the read into the holding register
                if (acc_word)
                  hold_q <= bus_data_in;
                else if (acc_q)
                  hold_q[7:0] <= rd_byte;
                else
                  hold_q[15:8] <= rd_byte;
              end
              if (!last_acc) begin
                acc_q <= 1'b1;
                st_q  <= ST_ADDR;
              end else if (!phase_q) begin
                phase_q <= 1'b1;
                acc_q   <= 1'b0;
                st_q    <= ST_ADDR;
              end else
                st_q <= ST_IDLE;
            end
          end
        end
        ST_RETRY: begin
          // rerun the same cycle once halt is released
          if (!halt_s)
            st_q <= ST_ADDR;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule // gdma_channel

`default_nettype wire

// file: verification/gdma_bus_mem.sv
/*
 * partner model: 32-byte memory on the asynchronous system bus.
 * assumes big-endian lanes, data held until the strobe is released.
 */
`timescale 1ns/100ps
`default_nettype none

module gdma_bus_mem (
  input  wire logic        clk,
  input  wire logic        as_n,
  input  wire logic        uds_n,
  input  wire logic        lds_n,
  input  wire logic        rw,
  input  wire logic [23:0] addr,
  input  wire logic [15:0] dout,
  input  wire logic        fail,
  input  wire logic [1:0]  lat,
  output logic      [15:0] din,
  output logic             dtack_n,
  output logic             berr_n
);
  logic [7:0] mem [0:31];
  logic [1:0] wait_q;
  logic [3:0] w;

  assign w = addr[4:1];
  initial begin
    din = 16'h0000;
    dtack_n = 1'b1;
    berr_n = 1'b1;
    wait_q = 2'h0;
  end
  // ************************************************************
  // answer each strobe after lat cycles, or with a bus error
  // ************************************************************
  always @(posedge clk) begin
    if (as_n) begin
      dtack_n <= 1'b1;
      berr_n <= 1'b1;
      wait_q <= lat;
      din <= ~din; // released: data no longer valid
    end else if (dtack_n && berr_n) begin
      if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else if (fail) begin
        berr_n <= 1'b0;
      end else begin
        dtack_n <= 1'b0;
        if (rw) begin
          din <= {mem[{w, 1'b0}], mem[{w, 1'b1}]};
        end
        if (!rw && !uds_n) begin
          mem[{w, 1'b0}] <= dout[15:8];
        end
        if (!rw && !lds_n) begin
          mem[{w, 1'b1}] <= dout[7:0];
        end
      end
    end
  end
endmodule // gdma_bus_mem
`default_nettype wire

// file: verification/gdma_channel_sva.sv
/*
 * checker for the dma channel top ports.
 * assumes binding onto gdma_channel; one clock domain.
 */
`timescale 1ns/100ps
`default_nettype none

module gdma_channel_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [23:0] bus_addr,
  input wire logic        bus_rw,
  input wire logic        bus_as_n,
  input wire logic        bus_uds_n,
  input wire logic        bus_lds_n,
  input wire logic        bus_data_oe,
  input wire logic        done_out_n,
  input wire logic        done_oe,
  input wire logic        interrupt_mask_bit,
  input wire logic        irq_request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ************************************************************
  // sequences and assertions
  // ************************************************************
  sequence s_mode_rd;
    psel && penable && pready && !pwrite && paddr == 8'h00;
  endsequence
  sequence s_held;
    !bus_as_n ##1 !bus_as_n;
  endsequence
  sequence s_masked;
    !interrupt_mask_bit ##1 !interrupt_mask_bit;
  endsequence
  a_mode_top_zero: assert property (s_mode_rd |-> !prdata[15])
    else $error("mode bit 15 reads one");
  a_addr_held: assert property (s_held |-> $stable(bus_addr))
    else $error("address moved in cycle");
  a_dir_held: assert property (s_held |-> $stable(bus_rw))
    else $error("direction moved in cycle");
  a_oe_write: assert property (bus_data_oe |-> !bus_rw)
    else $error("data driven on read");
  a_done_drive: assert property (!done_out_n |-> done_oe)
    else $error("done low but not driven");
  a_word_even: assert property (!bus_uds_n && !bus_lds_n |-> !bus_addr[0])
    else $error("word access at odd address");
  a_odd_lane: assert property (!bus_as_n && bus_addr[0] |-> bus_uds_n)
    else $error("odd byte on upper lane");
  a_strobe_in_as: assert property (!bus_uds_n || !bus_lds_n |-> !bus_as_n)
    else $error("data strobe outside cycle");
  a_irq_masked: assert property (s_masked |-> !irq_request)
    else $error("irq while masked");
endmodule // gdma_channel_sva

bind gdma_channel gdma_channel_sva u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .bus_addr(bus_addr), .bus_rw(bus_rw),
  .bus_as_n(bus_as_n), .bus_uds_n(bus_uds_n), .bus_lds_n(bus_lds_n),
  .bus_data_oe(bus_data_oe), .done_out_n(done_out_n), .done_oe(done_oe),
  .interrupt_mask_bit(interrupt_mask_bit), .irq_request(irq_request));
`default_nettype wire

// file: verification/tb_top.sv
/*
 * testbench: apb register access, aligned and unaligned moves,
 * bus error, soft reset. assumes the partner memory model.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, bus_rw, bus_as_n, bus_uds_n, bus_lds_n, bus_data_oe;
  logic [23:0] bus_addr;
  logic [15:0] bus_data_out, bus_data_in;
  logic        bus_dtack_n, bus_berr_n, irq_request, fail = 0;
  logic        interrupt_mask_bit = 1;
  logic [1:0]  lat = 2'h0;
  int          errors = 0, checks = 0, cyc = 0;

  always #20 pclk = ~pclk;
  gdma_channel u_gdma_channel (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr(), .bus_addr, .bus_fc(),
    .bus_rw, .bus_as_n, .bus_uds_n, .bus_lds_n, .bus_data_out, .bus_data_oe,
    .bus_data_in, .bus_dtack_n, .bus_berr_n, .bus_halt_n(1'b1),
    .bus_reset_n(1'b1), .bus_clear_input_n(1'b1),
    .peripheral_request_n(1'b1), .peripheral_acknowledge_n(),
    .done_in_n(1'b1), .done_out_n(), .done_oe(), .interrupt_mask_bit,
    .irq_request);
  gdma_bus_mem u_gdma_bus_mem (.clk(pclk), .as_n(bus_as_n), .uds_n(bus_uds_n),
    .lds_n(bus_lds_n), .rw(bus_rw), .addr(bus_addr), .dout(bus_data_out),
    .fail(fail), .lat(lat), .din(bus_data_in), .dtack_n(bus_dtack_n),
    .berr_n(bus_berr_n));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    checks++;
    if (v !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic poll(input int bitn);
    logic [31:0] r;
    int j;
    j = 0;
    do begin
      apb(0, 8'h14, 0, r);
      j++;
    end while (r[bitn] !== 1'b1 && j < 400);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs;
    logic [31:0] r;
    apb(0, 8'h00, 0, r);
    chk("mode reset", 0, r);
    apb(1, 8'h00, 32'h0000_8000, r);
    apb(0, 8'h00, 0, r);
    chk("mode top bit", 0, r);
    $display("test regs done");
  endtask
  task automatic t_move(input int k);
    logic [31:0] r;
    logic [15:0] m;
    logic [4:0]  s, d;
    int j;
    s = {4'h0, k[0]};
    d = {4'h8, k[1]};
    m = 16'h330d | (k == 1 ? 16'h0040 : 16'h0080) |
        (k == 2 ? 16'h0010 : 16'h0020); // one odd side alone is byte
    if (k > 1) m = m | 16'h0400; // max rate, else 12.5 percent share
    for (j = 0; j < 32; j++) u_gdma_bus_mem.mem[j] = (j < 16) ? 8'h40 + j : 0;
    lat <= k[1:0];
    interrupt_mask_bit <= (k != 3);
    apb(1, 8'h04, {27'h0, s}, r);
    apb(1, 8'h08, {27'h0, d}, r);
    apb(1, 8'h10, 32'h0000_0004, r);
    apb(1, 8'h00, {16'h0, m}, r);
    poll(0);
    apb(0, 8'h14, 0, r);
    chk("status", 1, r);
    chk("irq", {31'h0, k != 3}, {31'h0, irq_request});
    for (j = 0; j < 4; j++)
      chk("dest byte", 8'h40 + s + j, u_gdma_bus_mem.mem[d + j]);
    apb(0, 8'h04, 0, r);
    chk("src ptr", s + 4, r);
    apb(0, 8'h08, 0, r);
    chk("dst ptr", d + 4, r);
    apb(0, 8'h10, 0, r);
    chk("count", 0, r);
    apb(0, 8'h00, 0, r);
    chk("mode after", {16'h0, m & 16'hfffe}, r);
    apb(1, 8'h14, 32'h0000_000f, r);
    $display("test move %0d done", k);
  endtask
  task automatic t_err;
    logic [31:0] r;
    fail <= 1'b1;
    interrupt_mask_bit <= 1'b1;
    apb(1, 8'h04, 0, r);
    apb(1, 8'h08, 32'h0000_0010, r);
    apb(1, 8'h10, 32'h0000_0004, r);
    apb(1, 8'h00, 32'h0000_37a1, r);
    poll(2);
    apb(0, 8'h14, 0, r);
    chk("read error", 4, r);
    chk("err irq", 1, {31'h0, irq_request});
    fail <= 1'b0;
    apb(1, 8'h00, 32'h0000_0002, r);
    apb(0, 8'h00, 0, r);
    chk("mode cleared", 0, r);
    apb(0, 8'h14, 0, r);
    chk("status cleared", 0, r);
    $display("test error done");
  endtask

  // ************************************************************
  // main sequence and timeout
  // ************************************************************
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    for (int k = 0; k < 4; k++) t_move(k);
    t_err;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
